// file: rtl/pmic_efuse_regulator_control.sv
// Notes on behaviour
// R1: 12V fuse off at reset, gated by inputs
// R2: 5V fuse off at reset, gated by inputs
// R3: 12V overvoltage sets readable flag
// R4: 5V overvoltage sets readable flag
// R5: over-temperature stops fuse until it clears
// R6: 12V short limit held until flags cleared
// R7: 5V short limit held until 3.3V good
// R8: reverse current opens 5V fuse until zero
// R9: open-drain pin shows 5V fuse open
// R10: monitor enable resets off; host sets it
// R11: shutdown faults clear monitor enable bit
// R12: control bit selects monitor gain
// R13: core undervoltage pulls core good low
// R14: enable pin runs core; low clears bits
// R15: disable and hold writable only with key
// R16: write elsewhere clears unlock key
// R17: hold bit freezes core power good
// R18: disable bit stops core regulator
// R19: soft start end clears hold bit
// R20: core select 770 mV plus 5 mV steps
// R21: io select 2540 mV plus 40 mV steps
// R22: io undervoltage sets flag, pulls good low
// R23: io regulator start/stop with hysteresis
// R24: flags latch first fault until written
// R25: enable bit counts only with firmware pin
// R26: auto clears beat simultaneous host writes
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module pmic_efuse_regulator_control
    import pmic_ctrl_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              high_rail_input_ok,
    input  wire logic              low_rail_input_ok,
    input  wire logic              power_disable_pin,
    input  wire logic              firmware_control_pin,
    input  wire logic              core_regulator_enable_pin,
    input  wire logic              core_soft_start_done,
    input  wire logic              fused_supply_above_start,
    input  wire logic              fused_supply_above_stop,
    input  wire fault_in_t         faults,
    output logic                   high_fuse_on,
    output logic                   low_fuse_on,
    output logic                   high_short_limit,
    output logic                   low_short_limit,
    output logic                   low_fuse_open_indicator_out,
    output logic                   low_fuse_open_indicator_oe,
    output logic                   core_rail_power_good_out,
    output logic                   core_rail_power_good_oe,
    output logic                   io_rail_power_good_out,
    output logic                   io_rail_power_good_oe,
    output logic                   core_regulator_run,
    output logic                   io_regulator_run,
    output logic                   monitor_enable,
    output logic                   monitor_gain,
    output logic                   core_force_pwm,
    output logic                   io_force_pwm,
    output logic                   deglitch_long,
    output logic      [10:0]       core_target_mv,
    output logic      [11:0]       io_target_mv
);

    if (ADDR_W < 6 || ADDR_W > 32)
    begin : g_bad_addr
        $error("ADDR_W must lie between 6 and 32");
    end

    function automatic logic hit(input logic [2:0] idx, input logic [2:0] want);
        hit = (idx == want);
    endfunction

    function automatic logic [10:0] core_mv(input logic [5:0] code);
        core_mv = CORE_BASE_MV + ({5'h00, code} * CORE_STEP_MV);
    endfunction

    function automatic logic [11:0] io_mv(input logic [4:0] code);
        io_mv = IO_BASE_MV + ({7'h00, code} * IO_STEP_MV);
    endfunction

    logic [5:0] core_voltage_select;
    logic [4:0] io_voltage_select;
    logic       core_unlock_key_bit;
    logic [7:0] control;
    logic [7:0] status [2];
    logic       core_pg;
    logic       io_pg;
    logic       soft_start_seen;
    logic       od_level;

    // bus decode
    wire logic [2:0] reg_idx   = paddr[4:2];
    wire logic       addr_ok   = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:5] == '0)
                                 && (reg_idx <= IDX_LAST);
    wire logic       setup     = psel && !penable;
    wire logic       access    = psel && penable && pready;
    wire logic       reg_write = access && pwrite && addr_ok;
    wire logic       wr_core   = reg_write && hit(reg_idx, IDX_CORE_SEL);
    wire logic       wr_io     = reg_write && hit(reg_idx, IDX_IO_SEL);
    wire logic       wr_ctl    = reg_write && hit(reg_idx, IDX_CONTROL);

    // power-disable gating
    wire logic p3_en_effective = firmware_control_pin && control[CTL_POWER_DISABLE_ENABLE_BIT];         // [R25]
    wire logic p3_disable      = power_disable_pin
                                 && (!firmware_control_pin || p3_en_effective);

    wire logic next_high_on = high_rail_input_ok && !p3_disable
                              && !faults.high_ot;                                  // [R1] [R5]
    wire logic next_low_on  = low_rail_input_ok && !p3_disable
                              && !faults.low_ot && !faults.low_reverse;             // [R2] [R5] [R8]

    // status events
    wire logic [7:0] ev0 = {faults.high_uv, faults.low_uv, faults.io_uv, faults.core_uv,
                            faults.high_ot, faults.low_ot, faults.high_eotw,
                            faults.low_eotw};                                       // [R22]
    wire logic [7:0] ev1 = {faults.high_oc || faults.high_short,
                            faults.low_oc || faults.low_short,
                            faults.io_oc, faults.core_oc, 1'b0, 1'b0,
                            faults.high_ov, faults.low_ov};                         // [R3] [R4]
    wire logic [7:0] ev [2];
    assign ev[0] = ev0;
    assign ev[1] = ev1 & S1_LATCH_MASK;

    // first fault freezes both registers
    wire logic any_flag = (|status[0]) || (|(status[1] & S1_LATCH_MASK));          // [R24]

    // key and control
    wire logic next_key = reg_write ? (wr_io && pwdata[KEY_BIT])
                                    : core_unlock_key_bit;                          // [R16] [R26]

    wire logic soft_start_rise = core_soft_start_done && !soft_start_seen;
    wire logic fault_off = faults.high_ot || faults.low_ot || faults.low_reverse
                           || faults.core_oc || faults.io_oc;

    wire logic [7:0] ctl_written = {pwdata[7:2],
                                    core_unlock_key_bit ? pwdata[1:0]
                                                        : control[1:0]};            // [R15]
    wire logic [7:0] ctl_host = wr_ctl ? ctl_written : control;

    wire logic next_imonen = ctl_host[CTL_IMONEN] && !fault_off;                   // [R10] [R11]
    wire logic next_dis    = ctl_host[CTL_DIS] && core_regulator_enable_pin;        // [R14] [R26]
    wire logic next_hold   = ctl_host[CTL_HOLD] && core_regulator_enable_pin
                             && !soft_start_rise;                                   // [R14] [R19]
    wire logic [7:0] next_control = {ctl_host[7:3], next_imonen, next_hold, next_dis};

    wire logic next_high_limit = faults.high_short
                                 || (high_short_limit && any_flag);                 // [R6]
    wire logic next_low_limit  = faults.low_short
                                 || (low_short_limit && !io_pg);                    // [R7]

    wire logic next_io_run = fused_supply_above_start
                             || (io_regulator_run && fused_supply_above_stop);      // [R23]

    // read mux
    wire logic [7:0] status1_view = (status[1] & S1_LATCH_MASK)
                                    | ({7'h00, power_disable_pin} << S1_P3STATE);
    wire logic [7:0] rd_byte =
        hit(reg_idx, IDX_ID1)      ? ID1_VALUE :
        hit(reg_idx, IDX_ID2)      ? ID2_VALUE :
        hit(reg_idx, IDX_CORE_SEL) ? {2'h0, core_voltage_select} :
        hit(reg_idx, IDX_IO_SEL)   ? {2'h0, core_unlock_key_bit, io_voltage_select} :
        hit(reg_idx, IDX_CONTROL)  ? control :
        hit(reg_idx, IDX_STATUS0)  ? status[0] :
        hit(reg_idx, IDX_STATUS1)  ? status1_view : 8'h00;

    // apb slave: zero wait states, answer in access cycle
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            pready  <= setup;
            pslverr <= setup && !addr_ok;
            if (setup)
            begin
                prdata <= (!pwrite && addr_ok) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            end
        end
    end

    // voltage selects and key
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            core_voltage_select <= CORE_SEL_RESET;                                 // [R20]
            io_voltage_select   <= IO_SEL_RESET;                                   // [R21]
            core_unlock_key_bit <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wr_core)
            begin
                core_voltage_select <= pwdata[5:0];
            end
            if (wr_io)
            begin
                io_voltage_select <= pwdata[4:0];
            end
            core_unlock_key_bit <= next_key;                                       // [R16]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            control         <= CONTROL_RESET;                                      // [R10]
            soft_start_seen <= 1'b0;
        end
        else if (clk_en)
        begin
            control         <= next_control;
            soft_start_seen <= core_soft_start_done;
        end
    end

    // latched status registers; event beats a clearing write
    for (genvar i = 0; i < 2; i++)
    begin : g_status
        wire logic wr_this = reg_write && hit(reg_idx, IDX_STATUS0 + 3'(i));
        wire logic [7:0] next_status = (wr_this || !any_flag) ? ev[i] : status[i];  // [R24]
        always_ff @(posedge ref_clk)
        begin
            if (reset)
            begin
                status[i] <= 8'h00;
            end
            else if (clk_en)
            begin
                status[i] <= next_status;
            end
        end
    end

    // fuses and short-circuit limits
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            high_fuse_on     <= 1'b0;                                              // [R1]
            low_fuse_on      <= 1'b0;                                              // [R2]
            high_short_limit <= 1'b0;
            low_short_limit  <= 1'b0;
        end
        else if (clk_en)
        begin
            high_fuse_on     <= next_high_on;
            low_fuse_on      <= next_low_on;
            high_short_limit <= next_high_limit;                                   // [R6]
            low_short_limit  <= next_low_limit;                                    // [R7]
        end
    end

    // regulators and power-good
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            core_regulator_run <= 1'b0;
            io_regulator_run   <= 1'b0;
            core_pg            <= 1'b0;
            io_pg              <= 1'b0;
        end
        else if (clk_en)
        begin
            core_regulator_run <= core_regulator_enable_pin && !control[CTL_DIS];  // [R14] [R18]
            io_regulator_run   <= next_io_run;                                     // [R23]
            if (!control[CTL_HOLD])
            begin
                core_pg <= !faults.core_uv;                                        // [R13] [R17]
            end
            io_pg <= io_regulator_run && !faults.io_uv;                            // [R22]
        end
    end

    // pin-facing outputs; open-drain pins only ever pull low
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            od_level                    <= 1'b0;
            low_fuse_open_indicator_oe  <= 1'b1;
            core_rail_power_good_oe     <= 1'b1;
            io_rail_power_good_oe       <= 1'b1;
            monitor_enable              <= 1'b0;
            monitor_gain                <= 1'b0;
            core_force_pwm              <= 1'b0;
            io_force_pwm                <= 1'b0;
            deglitch_long               <= 1'b0;
            core_target_mv              <= core_mv(CORE_SEL_RESET);
            io_target_mv                <= io_mv(IO_SEL_RESET);
        end
        else if (clk_en)
        begin
            od_level                    <= 1'b0;
            low_fuse_open_indicator_oe  <= !next_low_on;                           // [R9]
            core_rail_power_good_oe     <= !core_pg;                               // [R13]
            io_rail_power_good_oe       <= !io_pg;                                 // [R22]
            monitor_enable              <= next_imonen;                            // [R11]
            monitor_gain                <= next_control[CTL_IMONG];                // [R12]
            core_force_pwm              <= next_control[CTL_CORE_PWM];
            io_force_pwm                <= next_control[CTL_IO_PWM];
            deglitch_long               <= next_control[CTL_DEGLITCH];
            core_target_mv              <= core_mv(core_voltage_select);           // [R20]
            io_target_mv                <= io_mv(io_voltage_select);               // [R21]
        end
    end

    assign low_fuse_open_indicator_out = od_level;
    assign core_rail_power_good_out    = od_level;
    assign io_rail_power_good_out      = od_level;

endmodule

// file: rtl/pmic_ctrl_pkg.sv
package pmic_ctrl_pkg;

    // register indices; byte address is four times the index
    localparam logic [2:0] IDX_ID1      = 3'h0;
    localparam logic [2:0] IDX_ID2      = 3'h1;
    localparam logic [2:0] IDX_CORE_SEL = 3'h2;
    localparam logic [2:0] IDX_IO_SEL   = 3'h3;
    localparam logic [2:0] IDX_CONTROL  = 3'h4;
    localparam logic [2:0] IDX_STATUS0  = 3'h5;
    localparam logic [2:0] IDX_STATUS1  = 3'h6;
    localparam logic [2:0] IDX_LAST     = 3'h6;

    // identity bytes: values are arbitrary
    localparam logic [7:0] ID1_VALUE = 8'ha5;
    localparam logic [7:0] ID2_VALUE = 8'h3c;

    localparam logic [5:0] CORE_SEL_RESET = 6'h22;
    localparam logic [4:0] IO_SEL_RESET   = 5'h13;
    localparam logic [7:0] CONTROL_RESET  = 8'h00;

    localparam int KEY_BIT      = 5;
    localparam int CTL_POWER_DISABLE_ENABLE_BIT     = 7;
    localparam int CTL_IMONG    = 6;
    localparam int CTL_IO_PWM   = 5;
    localparam int CTL_CORE_PWM = 4;
    localparam int CTL_DEGLITCH = 3;
    localparam int CTL_IMONEN   = 2;
    localparam int CTL_HOLD     = 1;
    localparam int CTL_DIS      = 0;
    localparam int S0_IO_UV     = 5;
    localparam int S1_P3STATE   = 3;
    localparam int S1_HIGH_FUSE_OVERVOLTAGE_FLAG      = 1;
    localparam int S1_OV5       = 0;

    // status1 bits that latch; p3 state is live, bit 2 unused
    localparam logic [7:0] S1_LATCH_MASK = 8'hf3;

    localparam logic [10:0] CORE_BASE_MV = 11'd770;
    localparam logic [10:0] CORE_STEP_MV = 11'd5;
    localparam logic [11:0] IO_BASE_MV   = 12'd2540;
    localparam logic [11:0] IO_STEP_MV   = 12'd40;

    // analog indications, all synchronous levels, high = condition present
    typedef struct packed {
        logic high_uv;
        logic low_uv;
        logic io_uv;
        logic core_uv;
        logic high_ot;
        logic low_ot;
        logic high_eotw;
        logic low_eotw;
        logic high_oc;
        logic low_oc;
        logic io_oc;
        logic core_oc;
        logic high_ov;
        logic low_ov;
        logic high_short;
        logic low_short;
        logic low_reverse;
    } fault_in_t;

endpackage

// file: verif/pmic_ctrl_props.sv
`timescale 1ns/1ns
module pmic_ctrl_props
    import pmic_ctrl_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    input wire logic              ref_clk,
    input wire logic              reset,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              high_rail_input_ok,
    input wire logic              core_regulator_enable_pin,
    input wire fault_in_t         faults,
    input wire logic              high_fuse_on,
    input wire logic              low_fuse_on,
    input wire logic              low_fuse_open_indicator_oe,
    input wire logic              io_rail_power_good_oe,
    input wire logic              core_regulator_run,
    input wire logic              monitor_enable
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    wire fault_off = faults.high_ot | faults.low_ot | faults.low_reverse | faults.core_oc
                   | faults.io_oc;

    a_apb_ready_slot: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single access cycle");
    a_unmapped_err: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("unaligned address without error");
    // reset itself is the antecedent here, so the default disable is switched off
    a_fuse_reset_off: assert property (disable iff (1'b0) reset |=> !high_fuse_on && !low_fuse_on)
        else $error("fuse on after reset");
    a_high_fuse_gate: assert property (high_fuse_on |-> $past(high_rail_input_ok && !faults.high_ot))
        else $error("high fuse on without its conditions");
    a_low_fuse_cut: assert property ($past(faults.low_reverse || faults.low_ot) |-> !low_fuse_on)
        else $error("low fuse on during reverse or over-temperature");
    a_open_ind_track: assert property (low_fuse_open_indicator_oe == !low_fuse_on)
        else $error("open indicator disagrees with low fuse");
    a_monitor_fault_clear: assert property (fault_off |=> ##[0:1] !monitor_enable)
        else $error("monitor enable survived a shutdown fault");
    a_core_run_pin: assert property (core_regulator_run |-> $past(core_regulator_enable_pin))
        else $error("core regulator runs with enable pin low");
    a_io_good_drop: assert property (faults.io_uv |-> ##[1:2] io_rail_power_good_oe)
        else $error("io power good not pulled low");

    c_refused: cover property (pslverr);
    c_reverse: cover property (faults.low_reverse ##1 !low_fuse_on);
    c_core_run: cover property (core_regulator_run);
    c_monitor: cover property (monitor_enable);
endmodule

bind pmic_efuse_regulator_control pmic_ctrl_props #(.ADDR_W(ADDR_W)) props_i (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .high_rail_input_ok(high_rail_input_ok),
    .core_regulator_enable_pin(core_regulator_enable_pin), .faults(faults),
    .high_fuse_on(high_fuse_on), .low_fuse_on(low_fuse_on),
    .low_fuse_open_indicator_oe(low_fuse_open_indicator_oe),
    .io_rail_power_good_oe(io_rail_power_good_oe),
    .core_regulator_run(core_regulator_run), .monitor_enable(monitor_enable)
);

// file: verif/power_stage_model.sv
`timescale 1ns/1ns
module power_stage_model #(
    parameter int SS_CYCLES = 8
)(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic core_run,
    input  wire logic low_fuse_on,
    output logic      soft_start_done,
    output logic      above_start,
    output logic      above_stop
);
    int ramp;

    always_ff @(posedge ref_clk)
    begin
        if (reset || !core_run)
            ramp <= 0;
        else if (ramp < SS_CYCLES)
            ramp <= ramp + 1;
        // supply lags the fuse; stop level drops one cycle later than start
        above_start <= low_fuse_on && !reset;
        above_stop  <= above_start || (low_fuse_on && !reset);
    end

    // level rises once the ramp completes, an edge for the hold release
    assign soft_start_done = (ramp == SS_CYCLES);
endmodule

// file: verif/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import pmic_ctrl_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] q; logic e;} row_t;
    logic        ref_clk, reset, psel, penable, pwrite, hi_ok, lo_ok, p3, fw, en_pin;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, ss_done, above_start, above_stop, hfuse, lfuse;
    logic        hlim, llim, ind_oe, core_run, mon_en, mon_gain;
    logic [10:0] core_mv;
    logic [11:0] io_mv;
    fault_in_t   faults;
    row_t        rows [14];
    int          n_mismatch, comparisons;
    wire         ind_wire = ind_oe ? 1'h0 : 1'h1;

    pmic_efuse_regulator_control pmic_efuse_regulator_control_i (
        .ref_clk(ref_clk), .reset(reset), .clk_en(1'h1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .high_rail_input_ok(hi_ok), .low_rail_input_ok(lo_ok),
        .power_disable_pin(p3), .firmware_control_pin(fw), .core_regulator_enable_pin(en_pin),
        .core_soft_start_done(ss_done), .fused_supply_above_start(above_start),
        .fused_supply_above_stop(above_stop), .faults(faults), .high_fuse_on(hfuse),
        .low_fuse_on(lfuse), .high_short_limit(hlim), .low_short_limit(llim),
        .low_fuse_open_indicator_out(), .low_fuse_open_indicator_oe(ind_oe),
        .core_rail_power_good_out(), .core_rail_power_good_oe(), .io_rail_power_good_out(),
        .io_rail_power_good_oe(), .core_regulator_run(core_run), .io_regulator_run(),
        .monitor_enable(mon_en), .monitor_gain(mon_gain), .core_force_pwm(),
        .io_force_pwm(), .deglitch_long(), .core_target_mv(core_mv), .io_target_mv(io_mv)
    );

    power_stage_model power_stage_model_i (
        .ref_clk(ref_clk), .reset(reset), .core_run(core_run), .low_fuse_on(lfuse),
        .soft_start_done(ss_done), .above_start(above_start), .above_stop(above_stop)
    );

    initial
    begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic summarize;
        $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // entered just after an edge; one idle cycle after so strobes never re-assert same step
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'h1; penable <= 1'h0; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'h1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'h1 && n < 20);
        if (pready !== 1'h1)
        begin
            n_mismatch++;
            summarize();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'h0; penable <= 1'h0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'h1, a, d, r, e);
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] q);
        logic [31:0] r;
        logic e;
        apb(1'h0, a, 8'h00, r, e);
        chk(nm, {24'h0, q}, r);
    endtask

    task automatic pulse_ov(input logic hi);
        if (hi) faults.high_ov <= 1'h1; else faults.low_ov <= 1'h1;
        tick(1);
        faults.high_ov <= 1'h0; faults.low_ov <= 1'h0;
        tick(1);
    endtask

    initial
    begin
        logic [31:0] r;
        logic e;
        reset = 1'h1; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00;
        pwdata = 32'h0; hi_ok = 1'h1; lo_ok = 1'h1; p3 = 1'h0; fw = 1'h1; en_pin = 1'h1;
        faults = '0;
        rows = '{'{1'h0, 8'h00, 8'h00, 8'ha5, 1'h0}, '{1'h0, 8'h04, 8'h00, 8'h3c, 1'h0},
                 '{1'h0, 8'h08, 8'h00, 8'h22, 1'h0}, '{1'h0, 8'h0c, 8'h00, 8'h13, 1'h0},
                 '{1'h0, 8'h10, 8'h00, 8'h00, 1'h0}, '{1'h1, 8'h00, 8'h11, 8'h00, 1'h0},
                 '{1'h0, 8'h00, 8'h00, 8'ha5, 1'h0}, '{1'h1, 8'h08, 8'h3f, 8'h00, 1'h0},
                 '{1'h0, 8'h08, 8'h00, 8'h3f, 1'h0}, '{1'h1, 8'h0c, 8'h1f, 8'h00, 1'h0},
                 '{1'h0, 8'h0c, 8'h00, 8'h1f, 1'h0}, '{1'h0, 8'h1c, 8'h00, 8'h00, 1'h1},
                 '{1'h1, 8'h02, 8'h01, 8'h00, 1'h1}, '{1'h0, 8'h40, 8'h00, 8'h00, 1'h1}};
        tick(3);
        reset <= 1'h0;
        tick(1);
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d, r, e);
            if (!rows[i].w) chk("rdata", {24'h0, rows[i].q}, r);
            chk("pslverr", {31'h0, rows[i].e}, {31'h0, e});
        end
        chk("core_mv", 32'd1085, {21'h0, core_mv});
        chk("io_mv", 32'd3780, {20'h0, io_mv});
        reset <= 1'h1;
        tick(3);
        chk("hfuse_rst", 32'h0, {31'h0, hfuse});
        chk("lfuse_rst", 32'h0, {31'h0, lfuse});
        chk("core_mv_rst", 32'd940, {21'h0, core_mv});
        chk("io_mv_rst", 32'd3300, {20'h0, io_mv});
        chk("mon_rst", 32'h0, {31'h0, mon_en});
        reset <= 1'h0;
        tick(3);
        chk("hfuse_on", 32'h1, {31'h0, hfuse});
        chk("ind_wire", 32'h1, {31'h0, ind_wire});
        p3 <= 1'h1;
        tick(3);
        chk("p3_no_en", 32'h1, {31'h0, lfuse});
        fw <= 1'h0;
        tick(3);
        chk("p3_fw_low", 32'h0, {31'h0, hfuse});
        chk("ind_wire", 32'h0, {31'h0, ind_wire});
        wr(8'h10, 8'h80);
        fw <= 1'h1;
        tick(3);
        chk("p3_en", 32'h0, {31'h0, lfuse});
        p3 <= 1'h0;
        wr(8'h10, 8'h03);
        rd("ctl_nokey", 8'h10, 8'h00);
        wr(8'h0c, 8'h33);
        wr(8'h10, 8'h03);
        rd("ctl_key", 8'h10, 8'h03);
        rd("key_clr", 8'h0c, 8'h13);
        chk("core_off", 32'h0, {31'h0, core_run});
        wr(8'h0c, 8'h33);
        wr(8'h10, 8'h02);
        for (int n = 0; n < 50 && ss_done !== 1'h1; n++) tick(1);
        // soft start that never ends is a hang, not a pass
        if (ss_done !== 1'h1)
        begin
            n_mismatch++;
            summarize();
        end
        tick(2);
        chk("core_on", 32'h1, {31'h0, core_run});
        rd("hold_clr", 8'h10, 8'h00);
        wr(8'h0c, 8'h33);
        wr(8'h10, 8'h03);
        en_pin <= 1'h0;
        tick(2);
        rd("pin_clr", 8'h10, 8'h00);
        chk("core_pin", 32'h0, {31'h0, core_run});
        en_pin <= 1'h1;
        pulse_ov(1'h1);
        rd("high_fuse_overvoltage_flag", 8'h18, 8'h02);
        pulse_ov(1'h0);
        rd("ov_latched", 8'h18, 8'h02);
        wr(8'h18, 8'h00);
        rd("st_clr", 8'h18, 8'h00);
        pulse_ov(1'h0);
        rd("ov5", 8'h18, 8'h01);
        wr(8'h10, 8'h44);
        chk("mon_en", 32'h1, {31'h0, mon_en});
        chk("mon_gain", 32'h1, {31'h0, mon_gain});
        faults.low_reverse <= 1'h1;
        tick(2);
        chk("mon_fault", 32'h0, {31'h0, mon_en});
        chk("rev_open", 32'h0, {31'h0, lfuse});
        faults.low_reverse <= 1'h0;
        tick(3);
        chk("rev_back", 32'h1, {31'h0, lfuse});
        faults.high_short <= 1'h1;
        tick(1);
        faults.high_short <= 1'h0;
        tick(3);
        chk("short_held", 32'h1, {31'h0, hlim});
        wr(8'h18, 8'h00);
        tick(2);
        chk("short_rel", 32'h0, {31'h0, hlim});
        // io undervoltage keeps io good low, so the 5V short limit must stay
        faults.io_uv <= 1'h1;
        faults.low_short <= 1'h1;
        tick(1);
        faults.low_short <= 1'h0;
        tick(2);
        chk("low_short_held", 32'h1, {31'h0, llim});
        faults.io_uv <= 1'h0;
        tick(3);
        chk("low_short_rel", 32'h0, {31'h0, llim});
        rd("io_flag", 8'h14, 8'h20);
        summarize();
    end
endmodule
